// ---- pod_output_disable.sv ----
`timescale 1ns/1ps
// Output-disable control between timer outputs and pins
module pod_output_disable #(
  parameter int NPINS = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Stop request from detection logic
  input wire logic stopReq,
  // Timer side
  input wire logic [NPINS-1:0] timerOut,
  input wire logic [NPINS-1:0] timerOe,
  input wire logic [NPINS-1:0] timerActLevel,
  // Pads
  input wire logic [NPINS-1:0] padIn,
  output logic [NPINS-1:0] padOut,
  output logic [NPINS-1:0] padOe,
  // Effective active level seen at pins
  output logic [NPINS-1:0] pinActLevel
);
  // ****************************************
  // State
  // ****************************************
  // Selects written by software
  logic [NPINS-1:0] hizSel_r, hizSel_nxt;
  logic [NPINS-1:0] portSel_r, portSel_nxt;
  logic [NPINS-1:0] invSel_r, invSel_nxt;
  // Port direction and data used once a pin is handed to port control
  logic [NPINS-1:0] dir_r, dir_nxt;
  logic [NPINS-1:0] odata_r, odata_nxt;
  // Stop latch
  logic stopped_r, stopped_nxt;
  // Bus response
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  // Pin side
  logic [NPINS-1:0] pinRd_r, pinRd_nxt;
  logic [NPINS-1:0] padOut_nxt, padOe_nxt, act_nxt;
  // Bus decode
  logic setupPh, wrEn, rdEn;
  logic wrCtrl, swStop, swClear;

  // All-zero word for unmapped, refused and write-only reads
  localparam logic [31:0] RST_ZERO_L = pod_pkg::RST_ZERO;

  // ****************************************
  // Helper functions
  // ****************************************
  // Widen a pin vector to one bus word, upper bits read zero
  function automatic logic [31:0] zext(input logic [NPINS-1:0] v);
    zext = RST_ZERO_L;
    zext[NPINS-1:0] = v;
  endfunction

  // Pin bits of a bus word; bit i belongs to pin i
  function automatic logic [NPINS-1:0] pinBits(input logic [31:0] d);
    pinBits = d[NPINS-1:0];
  endfunction

  // Offset that answers a read
  function automatic logic isMapped(input logic [7:0] a);
    unique case (a)
      pod_pkg::OFS_HIZ_SEL, pod_pkg::OFS_PORT_SEL, pod_pkg::OFS_INV_SEL,
      pod_pkg::OFS_DIR, pod_pkg::OFS_ODATA, pod_pkg::OFS_CTRL,
      pod_pkg::OFS_STATUS, pod_pkg::OFS_PIN_IN, pod_pkg::OFS_LEVEL: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // Offset that accepts a write; status, pin read and level are read-only
  function automatic logic isWritable(input logic [7:0] a);
    unique case (a)
      pod_pkg::OFS_HIZ_SEL, pod_pkg::OFS_PORT_SEL, pod_pkg::OFS_INV_SEL,
      pod_pkg::OFS_DIR, pod_pkg::OFS_ODATA, pod_pkg::OFS_CTRL: isWritable = 1'b1;
      default: isWritable = 1'b0;
    endcase
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  // Every transfer gets exactly one access cycle, so back-to-back transfers
  // need no extra bookkeeping here.
  // Setup cycle of any transfer; the reply comes in the following access cycle
  assign setupPh = psel && !penable;
  // A write lands at the edge that sees the access cycle with ready high
  assign wrEn = psel && penable && pwrite && pready;
  // Read data is fetched during setup so that it stands together with ready
  assign rdEn = setupPh && !pwrite;
  // Control word strobes
  assign wrCtrl = wrEn && (paddr == pod_pkg::OFS_CTRL);
  assign swStop = wrCtrl && pwdata[pod_pkg::CTRL_SW_STOP];
  assign swClear = wrCtrl && pwdata[pod_pkg::CTRL_CLEAR];

  // ****************************************
  // Output-disable selects
  // ****************************************
  // Next values: a mapped write replaces the whole pin vector
  always_comb begin
    hizSel_nxt = hizSel_r;
    portSel_nxt = portSel_r;
    invSel_nxt = invSel_r;
    if (wrEn) begin
      unique case (paddr)
        pod_pkg::OFS_HIZ_SEL: hizSel_nxt = pinBits(pwdata);
        pod_pkg::OFS_PORT_SEL: portSel_nxt = pinBits(pwdata);
        pod_pkg::OFS_INV_SEL: invSel_nxt = pinBits(pwdata);
        default: ;
      endcase
    end
  end

  // Registering only; selects clear on reset so pins start under timer control
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hizSel_r <= '0;
      portSel_r <= '0;
      invSel_r <= '0;
    end else begin
      hizSel_r <= hizSel_nxt;
      portSel_r <= portSel_nxt;
      invSel_r <= invSel_nxt;
    end
  end

  // ****************************************
  // Port direction and data
  // ****************************************
  // Next values: these only reach a pin once it is switched to port control
  always_comb begin
    dir_nxt = dir_r;
    odata_nxt = odata_r;
    if (wrEn) begin
      unique case (paddr)
        pod_pkg::OFS_DIR: dir_nxt = pinBits(pwdata);
        pod_pkg::OFS_ODATA: odata_nxt = pinBits(pwdata);
        default: ;
      endcase
    end
  end

  // Registering only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dir_r <= '0;
      odata_r <= '0;
    end else begin
      dir_r <= dir_nxt;
      odata_r <= odata_nxt;
    end
  end

  // ****************************************
  // Stop latch
  // ****************************************
  // A request sets the latch and holds it; software stop sets it as well.
  // Clearing only works while no request stands, so a live fault cannot be
  // wiped out by a late clear write.
  always_comb begin
    stopped_nxt = stopped_r || stopReq;
    if (swStop) begin
      stopped_nxt = 1'b1;
    end else if (swClear && !stopReq) begin
      stopped_nxt = 1'b0; // request wins over clear
    end
  end

  // Registering only; the stop is dropped by reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stopped_r <= 1'b0;
    end else begin
      stopped_r <= stopped_nxt;
    end
  end

  // ****************************************
  // Ready and error
  // ****************************************
  // Ready answers every setup cycle one cycle later, so the access phase
  // lasts exactly one cycle; the error flag rides with it.
  always_comb begin
    pready_nxt = setupPh;
    pslverr_nxt = 1'b0;
    if (setupPh) begin
      // Unmapped reads and writes to read-only or unmapped offsets are refused
      pslverr_nxt = pwrite ? !isWritable(paddr) : !isMapped(paddr);
    end
  end

  // Registering only; ready and error stand for the one access cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Read data is picked in setup and registered, so it stands exactly in the
  // access cycle; outside reads the bus shows zero.
  always_comb begin
    prdata_nxt = RST_ZERO_L;
    if (rdEn) begin
      unique case (paddr)
        pod_pkg::OFS_HIZ_SEL: prdata_nxt = zext(hizSel_r);
        pod_pkg::OFS_PORT_SEL: prdata_nxt = zext(portSel_r);
        pod_pkg::OFS_INV_SEL: prdata_nxt = zext(invSel_r);
        pod_pkg::OFS_DIR: prdata_nxt = zext(dir_r);
        pod_pkg::OFS_ODATA: prdata_nxt = zext(odata_r);
        pod_pkg::OFS_STATUS: prdata_nxt = {31'h0, stopped_r};
        pod_pkg::OFS_PIN_IN: prdata_nxt = zext(pinRd_r);
        pod_pkg::OFS_LEVEL: prdata_nxt = zext(pinActLevel);
        default: prdata_nxt = RST_ZERO_L; // control and refused reads give zero
      endcase
    end
  end

  // Registering only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= RST_ZERO_L;
    end else begin
      prdata <= prdata_nxt;
    end
  end

  // ****************************************
  // Per-pin drive cells
  // ****************************************
  // Priority per pin: float beats port switching, port switching beats timer.
  // A floated pin reads as zero rather than whatever the pad happens to show,
  // so software never acts on a wandering level.
  // Each cell picks timer, port or float drive for one pin
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : gPin
      pod_pin_cell uCell (
        .stopped(stopped_r),
        .hizSel(hizSel_r[g]),
        .portSel(portSel_r[g]),
        .invSel(invSel_r[g]),
        .timerOut(timerOut[g]),
        .timerOe(timerOe[g]),
        .portDir(dir_r[g]),
        .portData(odata_r[g]),
        .padIn(padIn[g]),
        .padOutNxt(padOut_nxt[g]),
        .padOeNxt(padOe_nxt[g]),
        .readNxt(pinRd_nxt[g])
      );
    end
  endgenerate

  // Active level seen at the pin flips with the inversion select
  assign act_nxt = timerActLevel ^ invSel_r;

  // ****************************************
  // Pad drive registers
  // ****************************************
  // Registering only; pads come up undriven until reset is released
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      padOut <= '0;
      padOe <= '0;
    end else begin
      padOut <= padOut_nxt;
      padOe <= padOe_nxt;
    end
  end

  // ****************************************
  // Pin read and level registers
  // ****************************************
  // Registering only; the captured read and the level start at zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pinRd_r <= '0;
      pinActLevel <= '0;
    end else begin
      pinRd_r <= pinRd_nxt;
      pinActLevel <= act_nxt;
    end
  end
endmodule

// ---- pod_pkg.sv ----
// Overview of operation
// - On stop request, pins with hi-Z select bit set float.
// - On stop request, pins with port-switch select bit set go to port control.
// - Both selects set: hi-Z wins, pin floats.
// - Port-controlled pins take direction and data from port registers.
// - Each timer output may be normal or inverted via function-select bit.
// - Inverted timer output inverts both configured active level and driven level.
// - Reading a floated pin returns undefined; here it reads zero.
// - Port-switched pins stay readable.
package pod_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_HIZ_SEL = 8'h00;
  localparam logic [7:0] OFS_PORT_SEL = 8'h04;
  localparam logic [7:0] OFS_INV_SEL = 8'h08;
  localparam logic [7:0] OFS_DIR = 8'h0c;
  localparam logic [7:0] OFS_ODATA = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_PIN_IN = 8'h1c;
  localparam logic [7:0] OFS_LEVEL = 8'h20;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_SW_STOP = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int STAT_STOPPED = 0;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage

// ---- pod_pin_cell.sv ----
`timescale 1ns/1ps
// One pin: selects timer, port or float drive
module pod_pin_cell (
  // Stop state and selects
  input wire logic stopped,
  input wire logic hizSel,
  input wire logic portSel,
  input wire logic invSel,
  // Sources
  input wire logic timerOut,
  input wire logic timerOe,
  input wire logic portDir,
  input wire logic portData,
  input wire logic padIn,
  // Pad drive
  output logic padOutNxt,
  output logic padOeNxt,
  output logic readNxt
);
  // ****************************************
  // Pin drive choice
  // ****************************************
  always_comb begin
    readNxt = padIn;
    if (stopped && hizSel) begin
      padOutNxt = 1'b0;
      padOeNxt = 1'b0;
      readNxt = 1'b0;
    end else if (stopped && portSel) begin
      padOutNxt = portData;
      padOeNxt = portDir;
    end else begin
      padOutNxt = timerOut ^ invSel;
      padOeNxt = timerOe;
    end
  end
endmodule

// ---- pod_checker.sv ----
`timescale 1ns/1ps
// ****
// Bus and level checks
// ****
module pod_checker #(
  parameter int NPINS = 16
) (
  // Clock and bus
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Levels
  input wire logic [NPINS-1:0] timerActLevel,
  input wire logic [NPINS-1:0] pinActLevel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Bus phases
  sequence setupPh;
    psel && !penable;
  endsequence
  sequence quietBus;
    !(psel && pwrite) [*3];
  endsequence
  a_ready_follows: assert property (setupPh |=> pready) else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held");
  a_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
  a_ready_access: assert property (pready |-> psel && penable) else $error("ready off access");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_data_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
  a_upper_zero: assert property (pready |-> prdata[31:NPINS] == '0) else $error("upper bits set");
  a_level_steady: assert property (quietBus |=> $stable(pinActLevel ^ timerActLevel))
    else $error("level moved");
endmodule
bind pod_output_disable pod_checker #(.NPINS(NPINS)) pod_checker_inst (.sys_clk, .reset, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .timerActLevel, .pinActLevel);

// ---- pod_power_stage.sv ----
`timescale 1ns/1ps
// Power stage seen from the pads
module pod_power_stage #(
  parameter int NPINS = 16
) (
  // Pad wires
  input wire logic sys_clk,
  input wire logic [NPINS-1:0] padOut,
  input wire logic [NPINS-1:0] padOe,
  output logic [NPINS-1:0] padIn
);
  logic [NPINS-1:0] floatPat_r = '0;
  // Undriven lines wander every cycle
  always_ff @(posedge sys_clk) floatPat_r <= ~floatPat_r;
  // Driven bits follow the pad
  assign padIn = (padOe & padOut) | (~padOe & floatPat_r);
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
// ****
// Output-disable bench
// ****
module tb;
  typedef struct packed {
    logic [15:0] hz;
    logic [15:0] ps;
    logic [15:0] iv;
    logic [15:0] dt;
    logic [1:0] st;
  } pod_row_t;
  localparam logic [15:0] TOUT = 16'ha5c3;
  localparam logic [15:0] TLVL = 16'h0ff0;
  logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic stopReq = 1'b0, pready, pslverr, er; // single disable unit drives all pins
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] timerOut = TOUT, timerOe = 16'hffff, timerActLevel = TLVL;
  logic [15:0] padIn, padOut, padOe, pinActLevel, hz, ps, ex;
  int miscompares = 0, samples_checked = 0;
  pod_row_t rows [4] = '{'{16'h00ff, 16'h0f0f, 16'h0000, 16'h1234, 2'd1},
    '{16'h0000, 16'hffff, 16'h00ff, 16'h5a5a, 2'd2},
    '{16'hffff, 16'h0000, 16'hffff, 16'h0000, 2'd0},
    '{16'hf000, 16'h000f, 16'h3c3c, 16'h000f, 2'd1}};
  // Clock
  always #5 sys_clk = ~sys_clk;
  pod_output_disable #(.NPINS(16)) pod_output_disable_inst (.sys_clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stopReq, .timerOut, .timerOe,
    .timerActLevel, .padIn, .padOut, .padOe, .pinActLevel);
  pod_power_stage #(.NPINS(16)) pod_power_stage_inst (.sys_clk, .padOut, .padOe, .padIn);
  // Verdict
  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compare
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(negedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    chk(padOe, 16'h0);
    reset <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd[15:0], 16'h0);
    end
    foreach (rows[i]) begin
      apb(1'b1, pod_pkg::OFS_HIZ_SEL, {16'h0, rows[i].hz});
      apb(1'b1, pod_pkg::OFS_PORT_SEL, {16'h0, rows[i].ps});
      apb(1'b1, pod_pkg::OFS_INV_SEL, {16'h0, rows[i].iv});
      apb(1'b1, pod_pkg::OFS_DIR, 32'h0000_ffff);
      apb(1'b1, pod_pkg::OFS_ODATA, {16'h0, rows[i].dt});
      stopReq <= (rows[i].st == 2'd1);
      @(posedge sys_clk);
      stopReq <= 1'b0;
      if (rows[i].st == 2'd2) begin
        apb(1'b1, pod_pkg::OFS_CTRL, 32'h1);
      end
      repeat (4) @(posedge sys_clk);
      hz = (rows[i].st != 2'd0) ? rows[i].hz : 16'h0;
      ps = (rows[i].st != 2'd0) ? rows[i].ps & ~rows[i].hz : 16'h0;
      ex = (ps & rows[i].dt) | (~ps & (TOUT ^ rows[i].iv));
      chk(padOe, ~hz);
      chk(padOut & ~hz, ex & ~hz);
      chk(pinActLevel, TLVL ^ rows[i].iv);
      apb(1'b0, pod_pkg::OFS_PIN_IN, 32'h0);
      chk(rd[15:0], ex & ~hz);
      apb(1'b0, pod_pkg::OFS_STATUS, 32'h0);
      chk(rd[15:0], {15'h0, rows[i].st != 2'd0});
      apb(1'b1, pod_pkg::OFS_CTRL, 32'h2);
    end
    // Unmapped offset is refused
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd[14:0]}, 16'h8000);
    // Software stop beats clear, and a standing request beats clear
    apb(1'b1, pod_pkg::OFS_CTRL, 32'h3);
    apb(1'b0, pod_pkg::OFS_STATUS, 32'h0);
    chk(rd[15:0], 16'h1);
    stopReq <= 1'b1;
    apb(1'b1, pod_pkg::OFS_CTRL, 32'h2);
    stopReq <= 1'b0;
    apb(1'b0, pod_pkg::OFS_STATUS, 32'h0);
    chk(rd[15:0], 16'h1);
    // Reset in mid-run drops the stop
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(padOe, 16'h0);
    reset <= 1'b0;
    apb(1'b0, pod_pkg::OFS_STATUS, 32'h0);
    chk(rd[15:0], 16'h0);
    tally_and_finish();
  end
endmodule
